// file: core/epi_ddr_out.sv
// Double-rate output register: one value after each rising, one after each falling edge
`timescale 1ns/1ps
`default_nettype none

module epi_ddr_out #(
  parameter int W = 6
) (
  input wire logic link_clk,
  input wire logic link_rst,
  input wire logic [W-1:0] rise_d,
  input wire logic [W-1:0] fall_d,
  output logic [W-1:0] q
);

  logic [W-1:0] pos_q;
  logic [W-1:0] neg_q;

  // XOR-encoded pair: no mux on the clock, so the output cannot glitch on a clock edge
  genvar i;
  for (i = 0; i < W; i++) begin : g_bit
    always_ff @(posedge link_clk) begin
      if (link_rst) begin
        pos_q[i] <= 1'b0;
      end else begin
        pos_q[i] <= rise_d[i] ^ neg_q[i];
      end
    end

    always_ff @(negedge link_clk) begin
      if (link_rst) begin
        neg_q[i] <= 1'b0;
      end else begin
        neg_q[i] <= fall_d[i] ^ pos_q[i];
      end
    end

    assign q[i] = pos_q[i] ^ neg_q[i];
  end

endmodule : epi_ddr_out

`default_nettype wire

// file: core/epi_phy_if.sv
// MAC-side PHY interface: RGMII, GMII and MII clocking, edges and byte crossing
// How it works
// RL1 - One interface type latched per instance
// RL2 - Instances share nothing, configure independently
// RL3 - RGMII: four data bits plus control per path
// RL4 - RGMII: MAC forwards transmit clock always
// RL5 - RGMII gigabit: 125 MHz, both edges used
// RL6 - RGMII 10/100: rising edge only
// RL7 - RGMII only on dedicated route
// RL8 - GMII/MII only on fabric route
// RL9 - GMII: launch falling, capture rising
// RL10 - Fabric registers transmit on falling edge
// RL11 - Fabric captures receive on rising edge
// RL12 - MII: PHY supplies both clocks
// RL13 - MII: transmit launched on falling edge
// RL14 - Fabric may retime MII transmit rising
// RL15 - Transmit clock capped: GMII 125, MII 25
// RL16 - MII data paths four bits wide
// RL17 - Supplier switches 10/100 clock glitch-free
// RL18 - Gigabit RGMII: low nibble rising first
`timescale 1ns/1ps
`default_nettype none

module epi_phy_if (
  input wire logic clock,
  input wire logic rst,
  input wire logic link_clk,
  input wire epi_pkg::epi_cfg_t cfg,
  input wire logic tx_valid,
  input wire epi_pkg::epi_byte_t tx_byte,
  output logic tx_ready,
  output logic rx_valid,
  output epi_pkg::epi_byte_t rx_byte,
  output logic cfg_err,
  output logic cfg_ok,
  output logic rgmii_txc,
  output logic [3:0] rgmii_txd,
  output logic rgmii_tx_ctl,
  input wire logic [3:0] rgmii_rxd,
  input wire logic rgmii_rx_ctl,
  output logic gmii_gtx_clk,
  output logic [7:0] gmii_txd,
  output logic gmii_tx_en,
  output logic gmii_tx_er,
  input wire logic [7:0] gmii_rxd,
  input wire logic gmii_rx_dv,
  input wire logic gmii_rx_er,
  output logic [3:0] mii_txd,
  output logic mii_tx_en,
  output logic mii_tx_er,
  input wire logic [3:0] mii_rxd,
  input wire logic mii_rx_dv,
  input wire logic mii_rx_er
);

  // ****************************************
  // System domain: configuration
  // ****************************************
  epi_pkg::epi_cfg_t cfg_q;
  logic loaded_q;
  logic cfg_ok_q;
  logic cfg_err_q;

  // RL1 latch once per instance
  // RL2 no state shared between instances
  always_ff @(posedge clock) begin
    if (rst) begin
      cfg_q <= epi_pkg::EPI_CFG_RST;
      loaded_q <= 1'b0;
      cfg_ok_q <= 1'b0;
      cfg_err_q <= 1'b0;
    end else if (!loaded_q) begin
      cfg_q <= cfg;
      loaded_q <= 1'b1;
      // RL7 RL8 RL15 route and clock cap checked here
      cfg_ok_q <= epi_pkg::epi_cfg_legal(cfg);
      cfg_err_q <= !epi_pkg::epi_cfg_legal(cfg);
    end
  end

  assign cfg_ok = cfg_ok_q;
  assign cfg_err = cfg_err_q;

  // ****************************************
  // System domain: transmit handshake
  // ****************************************
  epi_pkg::epi_byte_t tx_hold_q;
  logic req_q;
  logic ack_s1_q;
  logic ack_s2_q;
  logic tx_ready_q;
  logic ack_q;

  always_ff @(posedge clock) begin
    ack_s1_q <= ack_q;
    ack_s2_q <= ack_s1_q;
  end

  // Ready only returns once the link side has echoed the request back
  always_ff @(posedge clock) begin
    if (rst) begin
      req_q <= 1'b0;
      tx_hold_q <= epi_pkg::EPI_BYTE_RST;
      tx_ready_q <= 1'b0;
    end else begin
      if (tx_valid && tx_ready_q) begin
        req_q <= ~req_q;
        tx_hold_q <= tx_byte;
      end
      tx_ready_q <= cfg_ok_q && (req_q == ack_s2_q) && !(tx_valid && tx_ready_q);
    end
  end

  assign tx_ready = tx_ready_q;

  // ****************************************
  // System domain: receive delivery
  // ****************************************
  logic rx_tgl_q;
  epi_pkg::epi_byte_t rx_hold_q;
  logic rx_s1_q;
  logic rx_s2_q;
  logic rx_s3_q;
  logic rx_valid_q;
  epi_pkg::epi_byte_t rx_byte_q;

  always_ff @(posedge clock) begin
    if (rst) begin
      rx_s1_q <= 1'b0;
      rx_s2_q <= 1'b0;
      rx_s3_q <= 1'b0;
      rx_valid_q <= 1'b0;
      rx_byte_q <= epi_pkg::EPI_BYTE_RST;
    end else begin
      rx_s1_q <= rx_tgl_q;
      rx_s2_q <= rx_s1_q;
      rx_s3_q <= rx_s2_q;
      rx_valid_q <= rx_s2_q ^ rx_s3_q;
      if (rx_s2_q ^ rx_s3_q) begin
        rx_byte_q <= rx_hold_q;
      end
    end
  end

  assign rx_valid = rx_valid_q;
  assign rx_byte = rx_byte_q;

  // ****************************************
  // Link domain: synchronisers
  // ****************************************
  // Interface clocks are free running; the link side takes its reset and config only on link_clk edges
  logic lrst_s1_q;
  logic lrst_s2_q;
  epi_pkg::epi_cfg_t lcfg_s1_q;
  epi_pkg::epi_cfg_t lcfg_s2_q;
  logic lok_s1_q;
  logic lok_s2_q;
  logic req_s1_q;
  logic req_s2_q;

  always_ff @(posedge link_clk) begin
    lrst_s1_q <= rst;
    lrst_s2_q <= lrst_s1_q;
    lcfg_s1_q <= cfg_q;
    lcfg_s2_q <= lcfg_s1_q;
    lok_s1_q <= cfg_ok_q;
    lok_s2_q <= lok_s1_q;
    req_s1_q <= req_q;
    req_s2_q <= req_s1_q;
  end

  logic l_rgmii;
  logic l_gmii;
  logic l_mii;
  logic l_gig;
  logic l_wide;

  assign l_rgmii = lok_s2_q && (lcfg_s2_q.mode == epi_pkg::EPI_MODE_RGMII);
  assign l_gmii = lok_s2_q && (lcfg_s2_q.mode == epi_pkg::EPI_MODE_GMII);
  // RL12 MII clocks arrive from the PHY on link_clk
  assign l_mii = lok_s2_q && (lcfg_s2_q.mode == epi_pkg::EPI_MODE_MII);
  assign l_gig = l_rgmii && (lcfg_s2_q.speed == epi_pkg::EPI_SPD_1000);
  assign l_wide = l_gig || l_gmii;

  // ****************************************
  // Link domain: transmit sequencer
  // ****************************************
  epi_pkg::epi_txst_t st_q;
  epi_pkg::epi_txst_t st_d;
  epi_pkg::epi_byte_t cur_q;
  logic take;

  always_comb begin
    st_d = st_q;
    take = 1'b0;
    case (st_q)
      epi_pkg::EPI_TX_IDLE: begin
        if (lok_s2_q && (req_s2_q != ack_q)) begin
          take = 1'b1;
          st_d = epi_pkg::EPI_TX_LOW;
        end
      end
      epi_pkg::EPI_TX_LOW: begin
        st_d = l_wide ? epi_pkg::EPI_TX_IDLE : epi_pkg::EPI_TX_HIGH;
      end
      epi_pkg::EPI_TX_HIGH: begin
        st_d = epi_pkg::EPI_TX_IDLE;
      end
      default: begin
        st_d = epi_pkg::EPI_TX_IDLE;
      end
    endcase
  end

  always_ff @(posedge link_clk) begin
    if (lrst_s2_q) begin
      st_q <= epi_pkg::EPI_TX_IDLE;
      cur_q <= epi_pkg::EPI_BYTE_RST;
      ack_q <= 1'b0;
    end else begin
      st_q <= st_d;
      if (take) begin
        cur_q <= tx_hold_q;
        ack_q <= req_s2_q;
      end
    end
  end

  logic snd_en;
  logic [3:0] snd_nib;

  assign snd_en = (st_q != epi_pkg::EPI_TX_IDLE);
  // RL16 nibble paths, low nibble before high
  assign snd_nib = (st_q == epi_pkg::EPI_TX_HIGH) ? cur_q.data[7:4] : cur_q.data[3:0];

  // ****************************************
  // Link domain: fabric-side transmit pins
  // ****************************************
  // RL9 GMII launched on falling edge
  // RL13 MII launched on falling edge
  always_ff @(negedge link_clk) begin
    if (lrst_s2_q) begin
      gmii_txd <= 8'h00;
      gmii_tx_en <= 1'b0;
      gmii_tx_er <= 1'b0;
      mii_txd <= 4'h0;
      mii_tx_en <= 1'b0;
      mii_tx_er <= 1'b0;
    end else begin
      gmii_txd <= l_gmii && snd_en ? cur_q.data : 8'h00;
      gmii_tx_en <= l_gmii && snd_en;
      gmii_tx_er <= l_gmii && snd_en && cur_q.err;
      mii_txd <= l_mii && snd_en ? snd_nib : 4'h0;
      mii_tx_en <= l_mii && snd_en;
      mii_tx_er <= l_mii && snd_en && cur_q.err;
    end
  end

  // ****************************************
  // Link domain: double-rate outputs
  // ****************************************
  logic [6:0] ddr_rise;
  logic [6:0] ddr_fall;
  logic [6:0] fall_hold_q;
  logic [6:0] ddr_q;

  always_comb begin
    ddr_rise = 7'h00;
    ddr_fall = 7'h00;
    // RL4 forwarded transmit clock
    ddr_rise[6] = l_rgmii;
    ddr_rise[5] = l_gmii;
    if (l_gig) begin
      // RL5 both edges carry data
      // RL18 low nibble rising, high falling
      ddr_rise[4:0] = {snd_en, cur_q.data[3:0]};
      ddr_fall[4:0] = {snd_en ^ (snd_en && cur_q.err), cur_q.data[7:4]};
    end else if (l_rgmii) begin
      // RL6 same value on both edges
      ddr_rise[4:0] = {snd_en, snd_en ? snd_nib : 4'h0};
      ddr_fall[4:0] = ddr_rise[4:0];
    end
  end

  // RL18 falling half from same cycle
  // Without this hold the state change at the rising edge would leak into the falling half
  always_ff @(posedge link_clk) begin
    if (lrst_s2_q) begin
      fall_hold_q <= 7'h00;
    end else begin
      fall_hold_q <= ddr_fall;
    end
  end

  // RL3 four data bits plus control
  epi_ddr_out #(
    .W(7)
  ) u_ddr (
    .link_clk(link_clk),
    .link_rst(lrst_s2_q),
    .rise_d(ddr_rise),
    .fall_d(fall_hold_q),
    .q(ddr_q)
  );

  assign rgmii_txc = ddr_q[6];
  assign gmii_gtx_clk = ddr_q[5];
  assign rgmii_tx_ctl = ddr_q[4];
  assign rgmii_txd = ddr_q[3:0];

  // ****************************************
  // Link domain: receive capture
  // ****************************************
  logic [3:0] rg_d_rise_q;
  logic rg_c_rise_q;
  logic [3:0] rg_d_fall_q;
  logic rg_c_fall_q;
  logic [7:0] gm_d_q;
  logic gm_dv_q;
  logic gm_er_q;
  logic [3:0] mi_d_q;
  logic mi_dv_q;
  logic mi_er_q;

  // RL11 capture on rising edge
  always_ff @(posedge link_clk) begin
    rg_d_rise_q <= rgmii_rxd;
    rg_c_rise_q <= rgmii_rx_ctl;
    gm_d_q <= gmii_rxd;
    gm_dv_q <= gmii_rx_dv;
    gm_er_q <= gmii_rx_er;
    mi_d_q <= mii_rxd;
    mi_dv_q <= mii_rx_dv;
    mi_er_q <= mii_rx_er;
  end

  always_ff @(negedge link_clk) begin
    rg_d_fall_q <= rgmii_rxd;
    rg_c_fall_q <= rgmii_rx_ctl;
  end

  logic half_q;
  logic [3:0] lo_q;
  logic n_dv;
  logic n_er;
  logic [3:0] n_nib;

  assign n_dv = l_mii ? mi_dv_q : (l_rgmii && !l_gig && rg_c_rise_q);
  assign n_er = l_mii && mi_er_q;
  assign n_nib = l_mii ? mi_d_q : rg_d_rise_q;

  always_ff @(posedge link_clk) begin
    if (lrst_s2_q) begin
      half_q <= 1'b0;
      lo_q <= 4'h0;
      rx_tgl_q <= 1'b0;
      rx_hold_q <= epi_pkg::EPI_BYTE_RST;
    end else if (l_gig && rg_c_rise_q) begin
      // RL18 byte is rising nibble low, falling nibble high
      rx_hold_q <= {rg_d_fall_q, rg_d_rise_q, rg_c_rise_q ^ rg_c_fall_q};
      rx_tgl_q <= ~rx_tgl_q;
    end else if (l_gmii && gm_dv_q) begin
      rx_hold_q <= {gm_d_q, gm_er_q};
      rx_tgl_q <= ~rx_tgl_q;
    end else if (n_dv) begin
      half_q <= ~half_q;
      lo_q <= n_nib;
      if (half_q) begin
        rx_hold_q <= {n_nib, lo_q, n_er};
        rx_tgl_q <= ~rx_tgl_q;
      end
    end else begin
      half_q <= 1'b0;
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  a_cfg_one_mode: assert property (@(posedge clock) disable iff (rst) // RL1
    cfg_ok_q |-> $onehot(cfg_q.mode) && !cfg_err_q)
    else $error("active config has no single interface type");

  a_cfg_route_ok: assert property (@(posedge clock) disable iff (rst) // RL8
    cfg_ok_q |-> (cfg_q.fabric == (cfg_q.mode != epi_pkg::EPI_MODE_RGMII)))
    else $error("interface type on wrong route");

  a_cfg_freq_cap: assert property (@(posedge clock) disable iff (rst) // RL15
    cfg_ok_q && (cfg_q.mode == epi_pkg::EPI_MODE_MII) |-> epi_pkg::epi_tx_khz(cfg_q) <= epi_pkg::EPI_MAX_KHZ_MII)
    else $error("MII transmit clock above cap");

  a_tx_ready_drop: assert property (@(posedge clock) disable iff (rst) // RL1
    tx_valid && tx_ready_q |=> !tx_ready_q [*3])
    else $error("ready returned before link echo");

  a_rx_pulse_one: assert property (@(posedge clock) disable iff (rst) // RL11
    rx_valid_q |=> !rx_valid_q)
    else $error("receive strobe longer than one cycle");

  a_mii_nib_order: assert property (@(posedge link_clk) disable iff (lrst_s2_q) // RL16
    (st_q == epi_pkg::EPI_TX_LOW) && !l_wide |=> (st_q == epi_pkg::EPI_TX_HIGH) && $stable(cur_q))
    else $error("high nibble did not follow low nibble");

  a_gig_one_beat: assert property (@(posedge link_clk) disable iff (lrst_s2_q) // RL5
    (st_q == epi_pkg::EPI_TX_LOW) && l_wide |=> (st_q == epi_pkg::EPI_TX_IDLE))
    else $error("gigabit byte took more than one clock");

  a_sdr_same_edge: assert property (@(posedge link_clk) disable iff (lrst_s2_q) // RL6
    l_rgmii && !l_gig |-> ddr_rise[4:0] == ddr_fall[4:0])
    else $error("10/100 RGMII output changes on falling edge");

  a_mii_tx_launch: assert property (@(posedge link_clk) disable iff (lrst_s2_q) // RL13
    l_mii && snd_en && $stable(l_mii) |-> mii_tx_en && (mii_txd == snd_nib))
    else $error("MII nibble not launched on falling edge");

  a_txc_forward: assert property (@(posedge link_clk) disable iff (lrst_s2_q) // RL4
    l_rgmii |-> ddr_rise[6] && !ddr_fall[6])
    else $error("RGMII transmit clock not forwarded");

  c_mii_byte: cover property (@(posedge link_clk) disable iff (lrst_s2_q)
    l_mii && (st_q == epi_pkg::EPI_TX_LOW) ##1 (st_q == epi_pkg::EPI_TX_HIGH));

  c_gig_byte: cover property (@(posedge link_clk) disable iff (lrst_s2_q)
    l_gig && (st_q == epi_pkg::EPI_TX_LOW));

  c_rx_byte: cover property (@(posedge clock) disable iff (rst) rx_valid_q);

  c_cfg_reject: cover property (@(posedge clock) disable iff (rst) cfg_err_q);

endmodule : epi_phy_if

`default_nettype wire

// file: core/epi_pkg.sv
// Shared constants, types and config checks for the MAC PHY interface block
package epi_pkg;

  // ****************************************
  // Interface modes and speeds (one-hot)
  // ****************************************
  localparam logic [2:0] EPI_MODE_RGMII = 3'h1;
  localparam logic [2:0] EPI_MODE_GMII = 3'h2;
  localparam logic [2:0] EPI_MODE_MII = 3'h4;
  localparam logic [2:0] EPI_SPD_10 = 3'h1;
  localparam logic [2:0] EPI_SPD_100 = 3'h2;
  localparam logic [2:0] EPI_SPD_1000 = 3'h4;

  // ****************************************
  // Interface clock rates in kHz
  // ****************************************
  localparam int EPI_KHZ_1000 = 125000;
  localparam int EPI_KHZ_100 = 25000;
  localparam int EPI_KHZ_10 = 2500;
  localparam int EPI_MAX_KHZ_GMII = 125000;
  localparam int EPI_MAX_KHZ_MII = 25000;

  // ****************************************
  // Types
  // ****************************************
  typedef struct packed {
    logic [2:0] mode;
    logic [2:0] speed;
    logic fabric;
  } epi_cfg_t;

  typedef struct packed {
    logic [7:0] data;
    logic err;
  } epi_byte_t;

  typedef enum logic [2:0] {
    EPI_TX_IDLE = 3'h1,
    EPI_TX_LOW = 3'h2,
    EPI_TX_HIGH = 3'h4
  } epi_txst_t;

  localparam epi_cfg_t EPI_CFG_RST = 7'h00;
  localparam epi_byte_t EPI_BYTE_RST = 9'h000;

  function automatic int epi_tx_khz(input epi_cfg_t c);
    int k;
    k = 0;
    case (c.speed)
      EPI_SPD_1000: k = EPI_KHZ_1000;
      EPI_SPD_100: k = EPI_KHZ_100;
      EPI_SPD_10: k = EPI_KHZ_10;
      default: k = 0;
    endcase
    return k;
  endfunction : epi_tx_khz

  function automatic logic epi_cfg_legal(input epi_cfg_t c);
    logic ok;
    ok = $onehot(c.mode) && $onehot(c.speed);
    case (c.mode)
      EPI_MODE_RGMII: ok = ok && !c.fabric;
      EPI_MODE_GMII: ok = ok && c.fabric && (epi_tx_khz(c) <= EPI_MAX_KHZ_GMII) && (c.speed == EPI_SPD_1000);
      EPI_MODE_MII: ok = ok && c.fabric && (epi_tx_khz(c) <= EPI_MAX_KHZ_MII);
      default: ok = 1'b0;
    endcase
    return ok;
  endfunction : epi_cfg_legal

endpackage : epi_pkg

// file: verif/epi_phy_model.sv
// Behavioural PHY facing the MAC: collects transmit bytes, sources receive bytes
`timescale 1ns/1ps
`default_nettype none

module epi_phy_model (
  input wire logic link_clk,
  input wire epi_pkg::epi_cfg_t cfg,
  input wire logic [3:0] rgmii_txd,
  input wire logic rgmii_tx_ctl,
  output logic [3:0] rgmii_rxd,
  output logic rgmii_rx_ctl,
  input wire logic [7:0] gmii_txd,
  input wire logic gmii_tx_en,
  input wire logic gmii_tx_er,
  output logic [7:0] gmii_rxd,
  output logic gmii_rx_dv,
  output logic gmii_rx_er,
  input wire logic [3:0] mii_txd,
  input wire logic mii_tx_en,
  input wire logic mii_tx_er,
  output logic [3:0] mii_rxd,
  output logic mii_rx_dv,
  output logic mii_rx_er
);
  epi_pkg::epi_byte_t tx_q[$];
  logic [3:0] lo;
  logic e;
  logic half;
  wire logic rg = (cfg.mode == epi_pkg::EPI_MODE_RGMII);
  wire logic gig = (cfg.speed == epi_pkg::EPI_SPD_1000);
  wire logic nen = rg ? rgmii_tx_ctl : mii_tx_en;
  wire logic [3:0] nib = rg ? rgmii_txd : mii_txd;
  wire logic ner = rg ? 1'h0 : mii_tx_er;

  initial begin
    half = 1'h0;
    {rgmii_rxd, rgmii_rx_ctl, gmii_rxd, gmii_rx_dv, gmii_rx_er, mii_rxd, mii_rx_dv, mii_rx_er} = '0;
  end

  // ****************************************
  // Transmit capture
  // ****************************************
  // Sampling mid-phase keeps clear of the edges where the MAC launches
  // double rate nibbles
  always @(posedge link_clk) begin
    #16;
    if (rg && gig) begin
      if (rgmii_tx_ctl === 1'h1) begin
        lo = rgmii_txd;
        @(negedge link_clk) #16;
        tx_q.push_back({rgmii_txd, lo, ~rgmii_tx_ctl});
      end
    end else if (gig) begin
      if (gmii_tx_en === 1'h1) tx_q.push_back({gmii_txd, gmii_tx_er});
    end else if (nen === 1'h1) begin
      if (half) tx_q.push_back({nib, lo, e | ner});
      else lo = nib;
      e = ner;
      half = ~half;
    end else half = 1'h0;
  end

  // ****************************************
  // Receive source
  // ****************************************
  // Released data lines show the inverse of the last value, never a stale copy; control lines drop to zero
  // gigabit RGMII receive uses both edges; other modes set one value per link cycle
  task automatic send(input epi_pkg::epi_byte_t b);
    if (rg && gig) begin
      @(negedge link_clk) #16;
      rgmii_rxd = b.data[3:0];
      rgmii_rx_ctl = 1'h1;
      @(posedge link_clk) #16;
      rgmii_rxd = b.data[7:4];
      rgmii_rx_ctl = ~b.err;
    end else begin
      for (int i = 0; i < (gig ? 1 : 2); i++) begin
        @(negedge link_clk) #16;
        if (gig) {gmii_rxd, gmii_rx_dv, gmii_rx_er} = {b.data, 1'h1, b.err};
        else if (rg) {rgmii_rxd, rgmii_rx_ctl} = {b.data[4*i +: 4], 1'h1};
        else {mii_rxd, mii_rx_dv, mii_rx_er} = {b.data[4*i +: 4], 1'h1, b.err};
      end
    end
    @(negedge link_clk) #16;
    {rgmii_rxd, rgmii_rx_ctl, gmii_rxd, gmii_rx_dv, gmii_rx_er} = {~rgmii_rxd, 1'h0, ~gmii_rxd, 2'h0};
    {mii_rxd, mii_rx_dv, mii_rx_er} = {~mii_rxd, 2'h0};
  endtask : send
endmodule : epi_phy_model
`default_nettype wire

// file: verif/tb.sv
// Self-checking bench for the MAC PHY interface block against a PHY model
`timescale 1ns/1ps
`default_nettype none

module tb;
  logic clock, rst, link_clk, tx_valid, tx_ready, rx_valid, cfg_err, cfg_ok;
  logic rgmii_txc, rgmii_tx_ctl, rgmii_rx_ctl, gmii_gtx_clk, gmii_tx_en, gmii_tx_er, gmii_rx_dv, gmii_rx_er;
  logic mii_tx_en, mii_tx_er, mii_rx_dv, mii_rx_er;
  logic [3:0] rgmii_txd, rgmii_rxd, mii_txd, mii_rxd;
  logic [7:0] gmii_txd, gmii_rxd;
  epi_pkg::epi_cfg_t cfg;
  epi_pkg::epi_byte_t tx_byte, rx_byte;
  int error_cnt = 0;
  int n_compared = 0;
  int cyc = 0;

  epi_phy_if dut (.clock(clock), .rst(rst), .link_clk(link_clk), .cfg(cfg), .tx_valid(tx_valid),
    .tx_byte(tx_byte), .tx_ready(tx_ready), .rx_valid(rx_valid), .rx_byte(rx_byte), .cfg_err(cfg_err),
    .cfg_ok(cfg_ok), .rgmii_txc(rgmii_txc), .rgmii_txd(rgmii_txd), .rgmii_tx_ctl(rgmii_tx_ctl),
    .rgmii_rxd(rgmii_rxd), .rgmii_rx_ctl(rgmii_rx_ctl), .gmii_gtx_clk(gmii_gtx_clk), .gmii_txd(gmii_txd),
    .gmii_tx_en(gmii_tx_en), .gmii_tx_er(gmii_tx_er), .gmii_rxd(gmii_rxd), .gmii_rx_dv(gmii_rx_dv),
    .gmii_rx_er(gmii_rx_er), .mii_txd(mii_txd), .mii_tx_en(mii_tx_en), .mii_tx_er(mii_tx_er),
    .mii_rxd(mii_rxd), .mii_rx_dv(mii_rx_dv), .mii_rx_er(mii_rx_er));

  epi_phy_model phy (.link_clk(link_clk), .cfg(cfg), .rgmii_txd(rgmii_txd), .rgmii_tx_ctl(rgmii_tx_ctl),
    .rgmii_rxd(rgmii_rxd), .rgmii_rx_ctl(rgmii_rx_ctl), .gmii_txd(gmii_txd), .gmii_tx_en(gmii_tx_en),
    .gmii_tx_er(gmii_tx_er), .gmii_rxd(gmii_rxd), .gmii_rx_dv(gmii_rx_dv), .gmii_rx_er(gmii_rx_er),
    .mii_txd(mii_txd), .mii_tx_en(mii_tx_en), .mii_tx_er(mii_tx_er), .mii_rxd(mii_rxd),
    .mii_rx_dv(mii_rx_dv), .mii_rx_er(mii_rx_er));

  initial begin
    clock = 1'h0;
    forever #10 clock = ~clock;
  end

  initial begin
    link_clk = 1'h0;
    #7;
    forever #32 link_clk = ~link_clk;
  end

  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      summarize();
    end
  end

  task automatic check(input string what, input logic [8:0] seen, input logic [8:0] exp);
    n_compared++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : summarize

  // Held past three link edges so the link side enters reset too
  task automatic do_reset(input epi_pkg::epi_cfg_t c);
    @(posedge clock);
    rst <= 1'h1;
    cfg <= c;
    tx_valid <= 1'h0;
    repeat (12) @(posedge clock);
    rst <= 1'h0;
    repeat (2) @(posedge clock);
    @(negedge clock);
  endtask : do_reset

  task automatic xfer_tx(input epi_pkg::epi_byte_t b, input epi_pkg::epi_byte_t exp);
    logic r;
    r = 1'h0;
    @(posedge clock);
    tx_valid <= 1'h1;
    tx_byte <= b;
    for (int i = 0; i < 300 && !r; i++) begin
      @(negedge clock);
      r = (tx_ready === 1'h1);
      @(posedge clock);
    end
    tx_valid <= 1'h0;
    for (int i = 0; i < 300 && phy.tx_q.size() == 0; i++) @(posedge clock);
    check("tx byte", (phy.tx_q.size() > 0) ? phy.tx_q.pop_front() : 9'h1FF, exp);
  endtask : xfer_tx

  task automatic xfer_rx(input epi_pkg::epi_byte_t b, input epi_pkg::epi_byte_t exp);
    logic got;
    got = 1'h0;
    fork
      phy.send(b);
      for (int i = 0; i < 200 && !got; i++) begin
        @(negedge clock);
        got = (rx_valid === 1'h1);
      end
    join
    check("rx byte", got ? rx_byte : 9'h1FF, exp);
  endtask : xfer_rx

  // Two bytes each way, each sent only after the previous one is seen, one with the error flag where the mode carries it
  task automatic exercise(input epi_pkg::epi_cfg_t c, input logic keep_err);
    do_reset(c);
    check("cfg status", {7'h00, cfg_ok, cfg_err}, 9'h002);
    xfer_tx(9'h14B, {8'hA5, keep_err});
    xfer_tx(9'h078, 9'h078);
    xfer_rx(9'h187, {8'hC3, keep_err});
    xfer_rx(9'h12C, 9'h12C);
  endtask : exercise

  task automatic fwd_check(input logic g);
    @(posedge link_clk) #16;
    check("fwd clk high", {8'h00, g ? gmii_gtx_clk : rgmii_txc}, 9'h001);
    @(negedge link_clk) #16;
    check("fwd clk low", {8'h00, g ? gmii_gtx_clk : rgmii_txc}, 9'h000);
  endtask : fwd_check

  task automatic test_mii();
    exercise({epi_pkg::EPI_MODE_MII, epi_pkg::EPI_SPD_100, 1'h1}, 1'h1);
    exercise({epi_pkg::EPI_MODE_MII, epi_pkg::EPI_SPD_10, 1'h1}, 1'h1);
    $display("test_mii done");
  endtask : test_mii

  task automatic test_gmii();
    exercise({epi_pkg::EPI_MODE_GMII, epi_pkg::EPI_SPD_1000, 1'h1}, 1'h1);
    fwd_check(1'h1);
    $display("test_gmii done");
  endtask : test_gmii

  // Slow reduced mode carries no error flag, so it is expected as zero
  task automatic test_rgmii();
    exercise({epi_pkg::EPI_MODE_RGMII, epi_pkg::EPI_SPD_1000, 1'h0}, 1'h1);
    fwd_check(1'h0);
    exercise({epi_pkg::EPI_MODE_RGMII, epi_pkg::EPI_SPD_100, 1'h0}, 1'h0);
    fwd_check(1'h0);
    exercise({epi_pkg::EPI_MODE_RGMII, epi_pkg::EPI_SPD_10, 1'h0}, 1'h0);
    $display("test_rgmii done");
  endtask : test_rgmii

  task automatic test_illegal();
    epi_pkg::epi_cfg_t bad[5];
    bad = '{{epi_pkg::EPI_MODE_RGMII, epi_pkg::EPI_SPD_1000, 1'h1},
      {epi_pkg::EPI_MODE_GMII, epi_pkg::EPI_SPD_1000, 1'h0}, {epi_pkg::EPI_MODE_GMII, epi_pkg::EPI_SPD_100, 1'h1},
      {epi_pkg::EPI_MODE_MII, epi_pkg::EPI_SPD_1000, 1'h1}, {3'h3, epi_pkg::EPI_SPD_100, 1'h1}};
    foreach (bad[i]) begin
      do_reset(bad[i]);
      check("cfg status", {7'h00, cfg_ok, cfg_err}, 9'h001);
      @(posedge clock);
      tx_valid <= 1'h1;
      tx_byte <= 9'h14B;
      repeat (20) @(posedge clock);
      @(negedge clock);
      check("ready refused", {8'h00, tx_ready}, 9'h000);
    end
    $display("test_illegal done");
  endtask : test_illegal

  initial begin
    rst = 1'h1;
    cfg = '0;
    tx_valid = 1'h0;
    tx_byte = '0;
    test_mii();
    test_gmii();
    test_rgmii();
    test_illegal();
    summarize();
  end
endmodule : tb
`default_nettype wire
